//--- rtl/int_opts_pkg.sv
// What this block does
// - Normal mode: protected option bits take one write, only within 64 cycles of reset.
// - Special mode lets the protected option bits be rewritten at any time.
// - Clock watch enable, option bit 3, is writable at any time.
// - Option bits 7, 6 and 2 always read as zero.
// - Edge select 1: falling edges only; 0: low-level wired-OR request.
// - Stop-exit delay resets to 1; when set, wait 4064 cycles after wakeup.
// - Clock watch enable bit switches the clock monitor on and off.
// - Watchdog rate bits reset to 00 and divide E/2^15 by 1, 4, 16, 64.
// - Seventeen hardware interrupts plus one software trap; fifteen are I-bit maskable.
// - Every source has a fixed two-byte vector from $FFC0 up to reset at $FFFE.
// - High-priority line is masked during reset and on its own acceptance.
// - Software trap stacks and sets I; wins only when no unmasked request is pending.
// - No trap while another is pending; trap blocks others until handler's first instruction.
// - Illegal opcode takes a non-maskable interrupt through vector $FFF8.
// - Periodic tick at E/2^13..2^16, masked by I or the tick enable bit.
// - Reset sets both X and I, blocking all maskable and high-priority requests.
// - Software may clear X; only interrupt entry, return restore or reset can set it again.
// - High-priority line ranks above all I-bit sources, which keep their own order.
// - I-bit interrupt: flags are stacked first, then I is set, X unchanged.
// - X-bit interrupt sets X and I after stacking; return restores both bits.
// - Each on-chip source has a local enable; resets gated by disable and clock watch.
// - Special mode flag latched, inverted, from mode pin B alone when the window counter reaches 2 after reset.
package int_opts_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  OFF_OPTS       = 8'h00;
  localparam logic [7:0]  OFF_TIMER_MASK = 8'h04;
  localparam logic [7:0]  OFF_LOCAL_EN   = 8'h08;
  localparam logic [7:0]  OFF_STATUS     = 8'h0c;
  localparam int          BIT_EDGE_SEL   = 5;
  localparam int          BIT_STOP_DLY   = 4;
  localparam int          BIT_CLK_WATCH  = 3;
  localparam int          BIT_TICK_EN    = 6;
  localparam int          BIT_WD_DISABLE = 16;
  localparam logic        STOP_DLY_RST   = 1'b1;
  localparam logic [1:0]  WD_RATE_RST    = 2'h0;
  localparam int          NUM_PERIPH     = 13;
  localparam int          NUM_ISRC       = 15;

  // ==========================================================================
  // Vectors
  localparam logic [15:0] VEC_RESERVED   = 16'hffc0;
  localparam logic [15:0] VEC_SERIAL     = 16'hffd6;
  localparam logic [15:0] VEC_HP_LINE    = 16'hfff4;
  localparam logic [15:0] VEC_TRAP       = 16'hfff6;
  localparam logic [15:0] VEC_ILLEGAL    = 16'hfff8;
  localparam logic [15:0] VEC_WATCHDOG   = 16'hfffa;
  localparam logic [15:0] VEC_CLK_FAIL   = 16'hfffc;
  localparam logic [15:0] VEC_RESET      = 16'hfffe;
  localparam logic [3:0]  IDX_TICK       = 4'hd;
  localparam logic [3:0]  IDX_EXT_REQ    = 4'he;

  // ==========================================================================
  // Timing, in E-clock cycles (hclk is the E clock)
  localparam int          WINDOW_CYCLES  = 64;
  localparam int          MODE_CAPTURE   = 2;
  localparam int          STOP_DELAY_E   = 4064;
  localparam int          STOP_DELAY_CYC = STOP_DELAY_E;

  typedef struct packed {
    logic trap_fetch;
    logic illegal_op;
    logic tap_write;
    logic tap_x;
    logic tap_i;
    logic ret_restore;
    logic ret_x;
    logic ret_i;
    logic int_accept;
    logic first_insn_done;
    logic stop_wakeup;
  } cpu_event_s;

  typedef struct packed {
    logic        pending;
    logic        x_related;
    logic [15:0] vector;
  } int_request_s;

  typedef enum logic {
    STOP_RUN   = 1'b0,
    STOP_DELAY = 1'b1
  } stop_state_e;

endpackage

//--- rtl/interrupt_mask_and_options_logic.sv
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module interrupt_mask_and_options_logic #(
  parameter int TICK_BASE_LOG2 = 13,
  parameter int WDOG_BASE_LOG2 = 15,
  parameter int DIV_W          = 22
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic                      mode_pin_a,
  input  wire logic                      mode_pin_b,
  input  wire logic                      ext_req_n,
  input  wire logic                      high_priority_request_line_n,
  input  wire logic [12:0]               periph_req,
  input  wire logic                      watchdog_timeout,
  input  wire logic                      clock_fail,
  input  wire int_opts_pkg::cpu_event_s  cpu_ev,
  output int_opts_pkg::int_request_s     int_req,
  output logic                           trap_allowed,
  output logic      [1:0]                stacked_xi,
  output logic                           cond_x,
  output logic                           cond_i,
  output logic                           special_mode_flag,
  output logic                           clock_monitor_en,
  output logic                           watchdog_clock_en,
  output logic                           stop_resume,
  output logic                           reset_req,
  output logic      [15:0]               reset_vector
);
  import int_opts_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] mode_a_sync_r, mode_b_sync_r, ext_sync_r, hp_sync_r;
  logic       ext_prev_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_a_sync_r <= 2'h0;
      mode_b_sync_r <= 2'h0;
      ext_sync_r    <= 2'h3;
      hp_sync_r     <= 2'h3;
      ext_prev_r    <= 1'b1;
    end else begin
      mode_a_sync_r <= {mode_a_sync_r[0], mode_pin_a};
      mode_b_sync_r <= {mode_b_sync_r[0], mode_pin_b};
      ext_sync_r    <= {ext_sync_r[0], ext_req_n};
      hp_sync_r     <= {hp_sync_r[0], high_priority_request_line_n};
      ext_prev_r    <= ext_sync_r[1];
    end
  end

  wire ext_s = ext_sync_r[1];
  wire hp_s  = hp_sync_r[1];

  // ==========================================================================
  // AHB-Lite slave, zero wait states, always OKAY
  logic       dp_valid_r, dp_write_r;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r;

  wire addr_take = hsel & htrans[1] & hready;
  wire dp_wr     = dp_valid_r & dp_write_r;
  wire wr_opts   = dp_wr & (dp_addr_r == OFF_OPTS);
  wire wr_tmask  = dp_wr & (dp_addr_r == OFF_TIMER_MASK);
  wire wr_local  = dp_wr & (dp_addr_r == OFF_LOCAL_EN);

  // ==========================================================================
  // Options register and its write protection
  logic [6:0] win_cnt_r;
  logic       prot_once_r;
  logic       edge_sel_r, stop_dly_r, clk_watch_r;
  logic [1:0] wd_rate_r;

  wire win_open = (win_cnt_r < 7'(WINDOW_CYCLES));
  wire prot_ok  = special_mode_flag | (win_open & ~prot_once_r);
  wire [7:0] opts_rd = {2'h0, edge_sel_r, stop_dly_r, clk_watch_r, 1'b0, wd_rate_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_cnt_r         <= 7'h0;
      special_mode_flag <= 1'b0;
    end else begin
      if (win_open)
        win_cnt_r <= win_cnt_r + 7'h1;
      if (win_cnt_r == 7'(MODE_CAPTURE))
        special_mode_flag <= ~mode_b_sync_r[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot_once_r <= 1'b0;
      edge_sel_r  <= 1'b0;
      stop_dly_r  <= STOP_DLY_RST;
      clk_watch_r <= 1'b0;
      wd_rate_r   <= WD_RATE_RST;
    end else if (wr_opts) begin
      clk_watch_r <= hwdata[BIT_CLK_WATCH];
      if (prot_ok) begin
        edge_sel_r  <= hwdata[BIT_EDGE_SEL];
        stop_dly_r  <= hwdata[BIT_STOP_DLY];
        wd_rate_r   <= hwdata[1:0];
        prot_once_r <= ~special_mode_flag;
      end
    end
  end

  assign clock_monitor_en = clk_watch_r;

  // ==========================================================================
  // Local enables and periodic tick rate
  logic [NUM_PERIPH-1:0] local_en_r;
  logic                  wd_disable_r, tick_en_r;
  logic [1:0]            tick_rate_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_en_r   <= '0;
      wd_disable_r <= 1'b0;
      tick_en_r    <= 1'b0;
      tick_rate_r  <= 2'h0;
    end else begin
      if (wr_local) begin
        local_en_r   <= hwdata[NUM_PERIPH-1:0];
        wd_disable_r <= hwdata[BIT_WD_DISABLE];
      end
      if (wr_tmask) begin
        tick_en_r   <= hwdata[BIT_TICK_EN];
        tick_rate_r <= hwdata[1:0];
      end
    end
  end

  // ==========================================================================
  // Shared divider: tick and watchdog rates are taps of one counter
  logic [DIV_W-1:0] div_r;
  logic             tick_flag_r;

  wire [DIV_W-1:0] tick_mask = (DIV_W'(1) << (TICK_BASE_LOG2 + int'(tick_rate_r))) - DIV_W'(1);
  wire [DIV_W-1:0] wd_mask   = (DIV_W'(1) << (WDOG_BASE_LOG2 + 2 * int'(wd_rate_r)))
                               - DIV_W'(1);
  wire tick_pulse = &(div_r | ~tick_mask);
  wire wd_pulse   = &(div_r | ~wd_mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r             <= '0;
      watchdog_clock_en <= 1'b0;
    end else begin
      div_r             <= div_r + DIV_W'(1);
      watchdog_clock_en <= wd_pulse;
    end
  end

  // ==========================================================================
  // Request gathering and priority resolution
  logic       cond_x_r, cond_i_r, illegal_r, trap_r, trap_hold_r, ext_edge_r;
  logic       pend_r, xrel_r;
  logic [15:0] vec_r;

  wire ext_fall = ext_prev_r & ~ext_s;
  wire ext_live = edge_sel_r ? ext_edge_r : ~ext_s;
  wire [NUM_ISRC-1:0] i_src = {ext_live, tick_flag_r & tick_en_r,
                               periph_req & local_en_r};
  wire [NUM_ISRC-1:0] i_live = cond_i_r ? '0 : i_src;
  wire i_any  = |i_live;
  wire hp_req = ~hp_s & ~cond_x_r;

  // Highest set bit wins, which is the highest vector address.
  function automatic logic [3:0] top_index(input logic [NUM_ISRC-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int k = 0; k < NUM_ISRC; k++)
      if (v[k])
        idx = 4'(k);
    return idx;
  endfunction

  wire [3:0]  i_idx    = top_index(i_live);
  wire [15:0] i_vec    = VEC_SERIAL + {11'h0, i_idx, 1'b0};
  wire        other_any = illegal_r | hp_req | i_any;
  assign trap_allowed  = ~other_any & ~trap_r & ~trap_hold_r;
  wire trap_start = cpu_ev.trap_fetch & trap_allowed;

  // The trap's hold only admits its own vector, so nothing else is honoured.
  wire        res_pend = trap_hold_r ? trap_r : (illegal_r | trap_r | hp_req | i_any);
  wire        res_xrel = ~trap_hold_r & ~illegal_r & ~trap_r & hp_req;
  wire [15:0] res_vec  = (trap_hold_r | (trap_r & ~illegal_r)) ? VEC_TRAP :
                         illegal_r ? VEC_ILLEGAL :
                         hp_req    ? VEC_HP_LINE :
                         i_vec;

  wire acc      = cpu_ev.int_accept & pend_r;
  wire acc_ill  = acc & (vec_r == VEC_ILLEGAL);
  wire acc_trap = acc & (vec_r == VEC_TRAP);
  wire acc_ext  = acc & (vec_r == (VEC_SERIAL + {11'h0, IDX_EXT_REQ, 1'b0}));
  wire acc_tick = acc & (vec_r == (VEC_SERIAL + {11'h0, IDX_TICK, 1'b0}));

  // Sticky sources: a new event in the accepting cycle survives the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      illegal_r   <= 1'b0;
      trap_r      <= 1'b0;
      trap_hold_r <= 1'b0;
      ext_edge_r  <= 1'b0;
      tick_flag_r <= 1'b0;
    end else begin
      illegal_r   <= cpu_ev.illegal_op | (illegal_r & ~acc_ill);
      trap_r      <= trap_start | (trap_r & ~acc_trap);
      trap_hold_r <= trap_start | (trap_hold_r & ~cpu_ev.first_insn_done);
      ext_edge_r  <= (edge_sel_r & ext_fall) | (ext_edge_r & ~acc_ext);
      tick_flag_r <= tick_pulse | (tick_flag_r & ~acc_tick);
    end
  end

  // Reset comes out presenting the reset vector.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      xrel_r <= 1'b0;
      vec_r  <= VEC_RESET;
    end else begin
      pend_r <= res_pend & ~acc;
      xrel_r <= res_xrel;
      vec_r  <= res_vec;
    end
  end

  assign int_req.pending   = pend_r;
  assign int_req.x_related = xrel_r;
  assign int_req.vector    = vec_r;

  // ==========================================================================
  // Condition flag mask bits
  logic [1:0] stacked_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_x_r  <= 1'b1;
      cond_i_r  <= 1'b1;
      stacked_r <= 2'h3;
    end else if (acc) begin
      stacked_r <= {cond_x_r, cond_i_r};
      cond_i_r  <= 1'b1;
      if (xrel_r)
        cond_x_r <= 1'b1;
    end else if (cpu_ev.ret_restore) begin
      cond_x_r <= cpu_ev.ret_x;
      cond_i_r <= cpu_ev.ret_i;
    end else if (cpu_ev.tap_write) begin
      cond_x_r <= cond_x_r & cpu_ev.tap_x;
      cond_i_r <= cpu_ev.tap_i;
    end
  end

  assign cond_x     = cond_x_r;
  assign cond_i     = cond_i_r;
  assign stacked_xi = stacked_r;

  // ==========================================================================
  // Reset-type requests
  wire wd_fire  = watchdog_timeout & ~wd_disable_r;
  wire clk_fire = clock_fail & clk_watch_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_req    <= 1'b0;
      reset_vector <= VEC_RESET;
    end else begin
      reset_req    <= wd_fire | clk_fire;
      reset_vector <= clk_fire ? VEC_CLK_FAIL : wd_fire ? VEC_WATCHDOG : VEC_RESET;
    end
  end

  // ==========================================================================
  // Stop-mode exit delay
  stop_state_e stop_st_r;
  logic [11:0] stop_cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_st_r   <= STOP_RUN;
      stop_cnt_r  <= 12'h0;
      stop_resume <= 1'b0;
    end else begin
      stop_resume <= 1'b0;
      unique case (stop_st_r)
        STOP_RUN: begin
          if (cpu_ev.stop_wakeup && stop_dly_r) begin
            stop_st_r  <= STOP_DELAY;
            stop_cnt_r <= 12'(STOP_DELAY_CYC - 2);
          end else if (cpu_ev.stop_wakeup) begin
            stop_resume <= 1'b1;
          end
        end
        STOP_DELAY: begin
          if (stop_cnt_r == 12'h0) begin
            stop_st_r   <= STOP_RUN;
            stop_resume <= 1'b1;
          end else begin
            stop_cnt_r <= stop_cnt_r - 12'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Bus read path; unmapped offsets read zero. Data is sampled in the address
  // phase, so a read right behind a write to the same word sees the old value.
  wire [31:0] status_rd = {12'h0, prot_once_r, win_open, special_mode_flag, cond_i_r,
                           cond_x_r, i_src};
  wire [31:0] rd_mux =
    (haddr[7:0] == OFF_OPTS)       ? {24'h0, opts_rd} :
    (haddr[7:0] == OFF_TIMER_MASK) ? {25'h0, tick_en_r, 4'h0, tick_rate_r} :
    (haddr[7:0] == OFF_LOCAL_EN)   ? {15'h0, wd_disable_r, 3'h0, local_en_r} :
    (haddr[7:0] == OFF_STATUS)     ? status_rd : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 8'h0;
      hrdata_r   <= 32'h0;
    end else begin
      dp_valid_r <= addr_take;
      dp_write_r <= hwrite;
      dp_addr_r  <= haddr[7:0];
      if (addr_take && !hwrite)
        hrdata_r <= rd_mux;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_late_write_ignored;
    wr_opts && !prot_ok |=> $stable({edge_sel_r, stop_dly_r, wd_rate_r});
  endproperty
  a_late_write_ignored: assert property (p_late_write_ignored)
    else $error("Protected option bits changed outside the write window.");

  property p_special_rewrite;
    wr_opts && special_mode_flag |=> {edge_sel_r, stop_dly_r, wd_rate_r}
      == $past({hwdata[BIT_EDGE_SEL], hwdata[BIT_STOP_DLY], hwdata[1:0]});
  endproperty
  a_special_rewrite: assert property (p_special_rewrite)
    else $error("Special mode write to protected option bits was lost.");

  property p_clock_watch_any;
    wr_opts |=> clock_monitor_en == $past(hwdata[BIT_CLK_WATCH]);
  endproperty
  a_clock_watch_any: assert property (p_clock_watch_any)
    else $error("Clock watch enable did not follow the write.");

  property p_unimpl_zero;
    addr_take && !hwrite && haddr[7:0] == OFF_OPTS |=> hrdata[7:6] == 2'h0 && !hrdata[2];
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("Unimplemented option bits read as one.");

  property p_edge_capture;
    edge_sel_r && ext_fall |=> ext_edge_r;
  endproperty
  a_edge_capture: assert property (p_edge_capture)
    else $error("Falling edge on the external request was not captured.");

  sequence s_delayed_wake;
    stop_st_r == STOP_RUN && cpu_ev.stop_wakeup && stop_dly_r;
  endsequence
  property p_stop_hold;
    s_delayed_wake |=> !stop_resume [*8];
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("Processing resumed during the stop-exit delay.");

  property p_x_sticky;
    !cond_x_r && !(acc && xrel_r) && !cpu_ev.ret_restore |=> !cond_x_r;
  endproperty
  a_x_sticky: assert property (p_x_sticky)
    else $error("X bit was set by a software transfer.");

  property p_i_entry;
    acc && !xrel_r |=> cond_i_r && cond_x_r == $past(cond_x_r)
      && stacked_xi == $past({cond_x_r, cond_i_r});
  endproperty
  a_i_entry: assert property (p_i_entry)
    else $error("I-bit entry stacked or masked wrongly.");

  property p_x_entry;
    acc && xrel_r |=> cond_x_r && cond_i_r;
  endproperty
  a_x_entry: assert property (p_x_entry)
    else $error("High-priority entry did not set X and I.");

  property p_hp_first;
    hp_req && !illegal_r && !trap_r && !trap_hold_r |=> vec_r == VEC_HP_LINE;
  endproperty
  a_hp_first: assert property (p_hp_first)
    else $error("High-priority line lost to an I-bit source.");

  property p_trap_blocks;
    trap_hold_r |-> !pend_r || vec_r == VEC_TRAP;
  endproperty
  a_trap_blocks: assert property (p_trap_blocks)
    else $error("Another interrupt was offered during the trap.");

  property p_watchdog_gate;
    watchdog_timeout && !wd_disable_r |=> reset_req;
  endproperty
  a_watchdog_gate: assert property (p_watchdog_gate)
    else $error("Enabled watchdog timeout raised no reset request.");

endmodule

//--- tb/req_source_model.sv
`timescale 1ns/1ps
// ====================
// Far-side interrupt sources.
// They change just after an edge, as on-chip logic would.
module req_source_model (
  input  wire logic        hclk,
  input  wire logic [12:0] want,
  input  wire logic        want_hp,
  input  wire logic        want_ext,
  output logic      [12:0] periph_req,
  output logic             ext_req_n,
  output logic             hp_req_n
);
  initial begin
    periph_req = '0;
    ext_req_n  = 1'b1;
    hp_req_n   = 1'b1;
  end
  always @(posedge hclk) begin
    periph_req <= want;
    hp_req_n   <= ~want_hp;
    ext_req_n  <= ~want_ext;
  end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
// ====================
// Options register, masking and vectoring bench.
module testbench;
  import int_opts_pkg::*;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = '0;
  logic [1:0]   htrans = '0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = '0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic [12:0]  want = '0;
  logic         want_hp = 1'b0;
  logic         want_ext = 1'b0;
  logic         mode_b = 1'b1;
  logic         wdt = 1'b0;
  logic         cfail = 1'b0;
  logic         trap_allowed;
  logic         watchdog_clock_en;
  logic         reset_req;
  logic [15:0]  reset_vector;
  logic [12:0]  periph_req;
  logic         ext_req_n;
  logic         hp_req_n;
  cpu_event_s   cpu_ev = '0;
  cpu_event_s   ev;
  int_request_s int_req;
  logic [1:0]   stacked_xi;
  logic         cond_x;
  logic         cond_i;
  logic         special_mode_flag;
  logic         clock_monitor_en;
  logic         stop_resume;
  logic [31:0]  rd;
  logic [12:0]  r;
  logic [31:0]  seed = 32'h0000002b;
  int           fails = 0;
  int           cmp_count = 0;
  int           n;

  always #12.5 hclk = ~hclk;

  req_source_model req_source_model_inst (.hclk(hclk), .want(want), .want_hp(want_hp),
    .want_ext(want_ext),
    .periph_req(periph_req), .ext_req_n(ext_req_n), .hp_req_n(hp_req_n));

  // Short divider bases keep tick and watchdog periods small.
  interrupt_mask_and_options_logic #(.TICK_BASE_LOG2(2), .WDOG_BASE_LOG2(3))
    interrupt_mask_and_options_logic_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .mode_pin_a(1'b0),
    .mode_pin_b(mode_b), .ext_req_n(ext_req_n), .high_priority_request_line_n(hp_req_n),
    .periph_req(periph_req), .watchdog_timeout(wdt), .clock_fail(cfail),
    .cpu_ev(cpu_ev), .int_req(int_req), .trap_allowed(trap_allowed),
    .stacked_xi(stacked_xi), .cond_x(cond_x), .cond_i(cond_i),
    .special_mode_flag(special_mode_flag), .clock_monitor_en(clock_monitor_en),
    .watchdog_clock_en(watchdog_clock_en), .stop_resume(stop_resume),
    .reset_req(reset_req), .reset_vector(reset_vector));

  function automatic logic [12:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[12:0];
  endfunction

  // The highest pending index wins, two bytes per vector.
  function automatic logic [15:0] vec_of(input logic [12:0] q);
    vec_of = VEC_SERIAL;
    for (int k = 0; k < 13; k++) if (q[k]) vec_of = VEC_SERIAL + 16'(2 * k);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 32'(a);
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic pulse(input cpu_event_s e);
    @(posedge hclk);
    cpu_ev <= e;
    @(posedge hclk);
    cpu_ev <= '0;
    #1;
  endtask

  task automatic wait_pend();
    n = 0;
    while (int_req.pending !== 1'b1 && n < 20) begin
      @(posedge hclk);
      #1;
      n++;
    end
  endtask

  task automatic tap(input logic x, input logic i);
    ev = '0;
    ev.tap_write = 1'b1;
    ev.tap_x = x;
    ev.tap_i = i;
    pulse(ev);
  endtask

  task automatic accept();
    ev = '0;
    ev.int_accept = 1'b1;
    pulse(ev);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFF_OPTS, '0);
    chk(rd, 32'h10);
    chk(32'({cond_x, cond_i}), 32'h3);
    bus(1'b1, OFF_OPTS, 32'hff);
    bus(1'b0, OFF_OPTS, '0);
    chk(rd, 32'h3b);
    chk(32'(clock_monitor_en), 32'h1);
    bus(1'b1, OFF_OPTS, 32'h0);
    bus(1'b0, OFF_OPTS, '0);
    chk(rd, 32'h33);
    chk(32'(clock_monitor_en), 32'h0);
    chk(32'(special_mode_flag), 32'h0);
    bus(1'b0, 8'h40, '0);
    chk(rd, 32'h0);
    ev = '0;
    ev.stop_wakeup = 1'b1;
    pulse(ev);
    n = 1;
    while (stop_resume !== 1'b1 && n < 5000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk(32'(n), 32'(STOP_DELAY_E));
    bus(1'b1, OFF_LOCAL_EN, 32'h1fff);
    tap(1'b0, 1'b0);
    for (int t = 0; t < 5; t++) begin
      r = (t == 0) ? 13'h1fff : (t == 1) ? 13'h0001 : xs() | 13'h0001;
      want <= r;
      wait_pend();
      chk(32'(int_req.vector), 32'(vec_of(r)));
      accept();
      chk(32'({cond_x, cond_i, stacked_xi}), 32'h4);
      want <= '0;
      repeat (3) @(posedge hclk);
      tap(1'b0, 1'b0);
    end
    // A short low pulse must stay latched after the line returns high.
    want_ext <= 1'b1;
    repeat (2) @(posedge hclk);
    want_ext <= 1'b0;
    wait_pend();
    repeat (4) @(posedge hclk);
    #1;
    chk(32'({int_req.pending, int_req.vector}), 32'h1fff2);
    accept();
    tap(1'b0, 1'b0);
    repeat (3) @(posedge hclk);
    #1;
    chk(32'(int_req.pending), 32'h0);
    want_hp <= 1'b1;
    wait_pend();
    want <= 13'h1000;
    repeat (4) @(posedge hclk);
    #1;
    chk(32'({int_req.x_related, int_req.vector}), 32'h1fff4);
    accept();
    chk(32'({cond_x, cond_i, stacked_xi}), 32'hc);
    repeat (4) @(posedge hclk);
    #1;
    chk(32'(int_req.pending), 32'h0);
    ev = '0;
    ev.ret_restore = 1'b1;
    pulse(ev);
    @(posedge hclk);
    #1;
    chk(32'({cond_x, cond_i}), 32'h0);
    tap(1'b1, 1'b1);
    @(posedge hclk);
    #1;
    chk(32'({cond_x, cond_i}), 32'h1);
    want_hp <= 1'b0;
    wdt <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    chk(32'({reset_req, reset_vector}), 32'({1'b1, VEC_WATCHDOG}));
    bus(1'b1, OFF_LOCAL_EN, 32'h11fff);
    cfail <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    chk(32'(reset_req), 32'h0);
    bus(1'b1, OFF_OPTS, 32'h08);
    repeat (2) @(posedge hclk);
    #1;
    chk(32'({reset_req, reset_vector}), 32'({1'b1, VEC_CLK_FAIL}));
    wdt <= 1'b0;
    cfail <= 1'b0;
    want <= '0;
    // Second reset, strapped for a special mode.
    @(posedge hclk);
    hresetn <= 1'b0;
    mode_b <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (70) @(posedge hclk);
    #1;
    chk(32'({special_mode_flag, cond_x, cond_i}), 32'h7);
    bus(1'b1, OFF_OPTS, 32'h0);
    bus(1'b0, OFF_OPTS, '0);
    chk(rd, 32'h0);
    ev = '0;
    ev.stop_wakeup = 1'b1;
    pulse(ev);
    chk(32'(stop_resume), 32'h1);
    bus(1'b1, OFF_OPTS, 32'h31);
    bus(1'b0, OFF_OPTS, '0);
    chk(rd, 32'h31);
    #1;
    n = 0;
    while (watchdog_clock_en !== 1'b1 && n < 100) begin
      @(posedge hclk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (watchdog_clock_en !== 1'b1 && n < 100);
    chk(32'(n), 32'(8 * 4));
    ev = '0;
    ev.illegal_op = 1'b1;
    pulse(ev);
    wait_pend();
    chk(32'(int_req.vector), 32'(VEC_ILLEGAL));
    chk(32'(trap_allowed), 32'h0);
    accept();
    chk(32'(trap_allowed), 32'h1);
    report_and_stop();
  end
endmodule
